/* src/adcseq_top.sv */
// Purpose: conversion sequence control of a successive-approximation converter
// Assumes: front end drops any conversion in flight when conv_start pulses
// Notes:   APB slave with one wait state on every access
//
// Summary of operation
// R1: channel field picks one of 16 multiplexer inputs for the sequence.
// R2: eight-conversion bit chooses four or eight conversions per sequence.
// R3: repeat bit chooses one sequence then stop, or endless sequences.
// R4: multi-channel bit chooses one channel or a block of consecutive channels.
// R5: mode number is {repeat, multi, eight}, modes 0 to 7.
// R6: mode 0 converts selected channel four times into slots 0 to 3.
// R7: mode 1 converts selected channel eight times into slots 0 to 7.
// R8: mode 2 converts four consecutive channels once into slots 0 to 3.
// R9: mode 3 converts eight consecutive channels once into slots 0 to 7.
// R10: mode 4 repeats four conversions of selected channel into slots 0 to 3.
// R11: mode 5 repeats eight conversions of selected channel into slots 0 to 7.
// R12: mode 6 cycles four consecutive channels, each to its own slot.
// R13: mode 7 cycles eight consecutive channels, each to its own slot.
// R14: repeating sequences overwrite previous results.
// R15: a slot's done flag sets when that slot is written.
// R16: single-pass modes set the sequence flag after the final conversion.
// R17: repeating modes set the sequence flag after the first full sequence.
// R18: codes 0-7 external, 8-11 reserved, 12-15 high, low, midpoint, test.
// R19: multi modes ignore two low channel bits for four, three for eight.
// R20: control write aborts the running sequence and starts a new one.
// R21: abort clears the sequence flag and all slot done flags.
// R22: finished single-pass sequence idles until the next control write.
// R23: after reset flags are clear and nothing converts until a control write.
`timescale 1ns/100ps
module adcseq_top #(
   parameter int NUM_SLOTS = 8,
   parameter int RES_W     = 10
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic                  conv_start,
   output logic      [3:0]       conv_channel,
   input  wire logic             conv_done,
   input  wire logic [RES_W-1:0] conv_result,
   output logic      [7:0]       conversion_done_flags,
   output logic                  sequence_done_flag
);
   generate
      if (NUM_SLOTS != adcseq_pkg::ADCSEQ_LEN_LONG || RES_W < 8 || RES_W > 16)
      begin : g_bad_param
         $error("adcseq_top: NUM_SLOTS must be 8 and RES_W 8 to 16");
      end
   endgenerate

   adcseq_pkg::adcseq_state_t state_q, state_d;
   logic [3:0]       chan_q, chan_d;
   logic [2:0]       mode_q, mode_d;
   logic [2:0]       slot_q, slot_d;
   logic [7:0]       done_q, done_d;
   logic             seq_q, seq_d;
   logic             start_q, start_d;
   logic [3:0]       cch_q, cch_d;
   logic             rdy_q, rdy_d;
   logic             err_q, err_d;
   logic [31:0]      rdata_q, rdata_d;
   logic [3:0]       map_chan;
   logic [RES_W-1:0] bank_rd;
   logic             acc, ctrl_wr, res_hit, last_slot, res_wr;

   assign acc       = psel && penable && rdy_q;
   assign ctrl_wr   = acc && pwrite && (paddr == adcseq_pkg::ADCSEQ_CTRL_OFF);
   assign res_hit   = (paddr >= adcseq_pkg::ADCSEQ_RES_BASE)
                   && (paddr <= adcseq_pkg::ADCSEQ_RES_END) && (paddr[1:0] == 2'h0);
   assign last_slot = mode_q[adcseq_pkg::ADCSEQ_MODE_EIGHT]
                    ? (slot_q == 3'(adcseq_pkg::ADCSEQ_LEN_LONG - 1))
                    : (slot_q == 3'(adcseq_pkg::ADCSEQ_LEN_SHORT - 1));   // R2
   // a done arriving alongside a control write belongs to the aborted run
   assign res_wr    = (state_q == adcseq_pkg::ADCSEQ_WAIT) && conv_done && !ctrl_wr;

   adcseq_chan_map u_map (
      .base_chan (chan_q),
      .multi     (mode_q[adcseq_pkg::ADCSEQ_MODE_MULTI]),
      .eight     (mode_q[adcseq_pkg::ADCSEQ_MODE_EIGHT]),
      .slot      (slot_q),
      .chan      (map_chan)
   );

   adcseq_result_bank #(
      .SLOTS (NUM_SLOTS),
      .WIDTH (RES_W)
   ) u_bank (
      .clk     (pclk),
      .rst_n   (presetn),
      .wr_en   (res_wr),
      .wr_idx  (slot_q),
      .wr_data (conv_result),
      .rd_idx  (paddr[4:2]),
      .rd_data (bank_rd)
   );

   // sequencer
   always_comb
   begin
      state_d = state_q;
      chan_d  = chan_q;
      mode_d  = mode_q;
      slot_d  = slot_q;
      done_d  = done_q;
      seq_d   = seq_q;
      start_d = 1'b0;
      cch_d   = cch_q;
      case (state_q)
         adcseq_pkg::ADCSEQ_IDLE:
            state_d = adcseq_pkg::ADCSEQ_IDLE;                 // R22 R23
         adcseq_pkg::ADCSEQ_START:
         begin
            start_d = 1'b1;
            cch_d   = map_chan;                                // R1 R18 R4
            state_d = adcseq_pkg::ADCSEQ_WAIT;
         end
         adcseq_pkg::ADCSEQ_WAIT:
         begin
            if (conv_done)
            begin
               done_d[slot_q] = 1'b1;                          // R15
               if (last_slot)
               begin
                  seq_d  = 1'b1;                               // R16 R17
                  slot_d = 3'h0;
                  if (mode_q[adcseq_pkg::ADCSEQ_MODE_REPEAT])
                     state_d = adcseq_pkg::ADCSEQ_START;       // R3 R10 R11 R12 R13
                  else
                     state_d = adcseq_pkg::ADCSEQ_IDLE;        // R3 R6 R7 R8 R9
               end
               else
               begin
                  slot_d  = slot_q + 3'h1;
                  state_d = adcseq_pkg::ADCSEQ_START;
               end
            end
         end
         default:
            state_d = adcseq_pkg::ADCSEQ_IDLE;
      endcase
      if (ctrl_wr)
      begin
         chan_d  = pwdata[adcseq_pkg::ADCSEQ_CHAN_LSB +: 4];
         mode_d  = {pwdata[adcseq_pkg::ADCSEQ_REPEAT_BIT],
                    pwdata[adcseq_pkg::ADCSEQ_MULTI_BIT],
                    pwdata[adcseq_pkg::ADCSEQ_EIGHT_BIT]};     // R5
         slot_d  = 3'h0;
         done_d  = 8'h00;                                      // R21
         seq_d   = 1'b0;                                       // R21
         start_d = 1'b0;
         state_d = adcseq_pkg::ADCSEQ_START;                   // R20
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= adcseq_pkg::ADCSEQ_IDLE;
         chan_q  <= adcseq_pkg::ADCSEQ_CHAN_RST;
         mode_q  <= adcseq_pkg::ADCSEQ_MODE_RST;
         slot_q  <= 3'h0;
         done_q  <= 8'h00;
         seq_q   <= 1'b0;
         start_q <= 1'b0;
         cch_q   <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         chan_q  <= chan_d;
         mode_q  <= mode_d;
         slot_q  <= slot_d;
         done_q  <= done_d;
         seq_q   <= seq_d;
         start_q <= start_d;
         cch_q   <= cch_d;
      end
   end

   // APB slave; ready from a flop costs one wait state but keeps outputs clean
   always_comb
   begin
      rdy_d   = psel && penable && !rdy_q;
      err_d   = 1'b0;
      rdata_d = rdata_q;
      if (psel && penable && !rdy_q)
      begin
         rdata_d = 32'h0000_0000;
         if (paddr == adcseq_pkg::ADCSEQ_CTRL_OFF)
         begin
            rdata_d[adcseq_pkg::ADCSEQ_CHAN_LSB +: 4]   = chan_q;
            rdata_d[adcseq_pkg::ADCSEQ_EIGHT_BIT]       = mode_q[adcseq_pkg::ADCSEQ_MODE_EIGHT];
            rdata_d[adcseq_pkg::ADCSEQ_MULTI_BIT]       = mode_q[adcseq_pkg::ADCSEQ_MODE_MULTI];
            rdata_d[adcseq_pkg::ADCSEQ_REPEAT_BIT]      = mode_q[adcseq_pkg::ADCSEQ_MODE_REPEAT];
         end
         else if ((paddr == adcseq_pkg::ADCSEQ_STAT_OFF) && !pwrite)
         begin
            rdata_d[adcseq_pkg::ADCSEQ_STAT_DONE_LSB +: 8] = done_q;
            rdata_d[adcseq_pkg::ADCSEQ_STAT_SEQ_BIT]       = seq_q;
            rdata_d[adcseq_pkg::ADCSEQ_STAT_BUSY_BIT]      =
               (state_q != adcseq_pkg::ADCSEQ_IDLE);
            rdata_d[adcseq_pkg::ADCSEQ_STAT_SLOT_LSB +: 3] = slot_q;
            rdata_d[adcseq_pkg::ADCSEQ_STAT_CHAN_LSB +: 4] = cch_q;
         end
         else if (res_hit && !pwrite)
            rdata_d[RES_W-1:0] = bank_rd;
         else
            err_d = 1'b1;   // status and slot writes land here as well
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdy_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         rdy_q   <= rdy_d;
         err_q   <= err_d;
         rdata_q <= rdata_d;
      end
   end

   assign prdata                = rdata_q;
   assign pready                = rdy_q;
   assign pslverr               = err_q;
   assign conv_start            = start_q;
   assign conv_channel          = cch_q;
   assign conversion_done_flags = done_q;
   assign sequence_done_flag    = seq_q;

   // checks
   sequence s_abort_clear;
      (done_q == 8'h00) && !seq_q;
   endsequence
   sequence s_restart;
      start_q && (slot_q == 3'h0);
   endsequence

   AST_ABORT_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // R20
      ctrl_wr |=> s_abort_clear ##1 s_restart)
      else $error("control write did not restart from slot 0");
   AST_ABORT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn) // R21
      ctrl_wr |=> (conversion_done_flags == 8'h00) && !sequence_done_flag)
      else $error("flags not cleared by control write");
   AST_SLOT_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R15
      res_wr |=> conversion_done_flags[$past(slot_q)])
      else $error("slot done flag not set on result write");
   AST_SEQ_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R16
      res_wr && last_slot |=> sequence_done_flag)
      else $error("sequence flag not set after last conversion");
   AST_SEQ_EARLY: assert property (@(posedge pclk) disable iff (!presetn) // R17
      $rose(sequence_done_flag) |-> $past(res_wr && last_slot))
      else $error("sequence flag set before sequence end");
   AST_SINGLE_STOP: assert property (@(posedge pclk) disable iff (!presetn || ctrl_wr) // R22
      res_wr && last_slot && !mode_q[2] |=> (state_q == adcseq_pkg::ADCSEQ_IDLE) [*3])
      else $error("single pass did not stop");
   AST_REPEAT_WRAP: assert property (@(posedge pclk) disable iff (!presetn) // R3
      res_wr && last_slot && mode_q[2] |=> ##1 s_restart)
      else $error("repeat mode did not wrap to slot 0");
   AST_LEN: assert property (@(posedge pclk) disable iff (!presetn) // R2
      conv_start |-> (mode_q[0] || (slot_q < 3'h4)))
      else $error("short sequence ran past slot 3");
   AST_SINGLE_CHAN: assert property (@(posedge pclk) disable iff (!presetn) // R4
      conv_start && !mode_q[1] |-> conv_channel == chan_q)
      else $error("single-channel mode changed channel");
   AST_MULTI_CHAN: assert property (@(posedge pclk) disable iff (!presetn) // R19
      conv_start && mode_q[1] && !mode_q[0]
         |-> conv_channel == {chan_q[3:2], slot_q[1:0]})
      else $error("four-channel block misaligned");
   AST_IDLE_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // R23
      state_q == adcseq_pkg::ADCSEQ_IDLE |-> !conv_start)
      else $error("conversion started while idle");

   sequence s_issue;
      conv_start && (conv_channel == $past(map_chan));
   endsequence

   AST_ISSUE: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (state_q == adcseq_pkg::ADCSEQ_START) && !ctrl_wr |=> s_issue)
      else $error("conversion not issued on the mapped channel");
   AST_EIGHT_CHAN: assert property (@(posedge pclk) disable iff (!presetn) // R19
      conv_start && mode_q[1] && mode_q[0]
         |-> conv_channel == {chan_q[3], slot_q})
      else $error("eight-channel block misaligned");
   AST_SEQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R17
      $fell(sequence_done_flag) |-> $past(ctrl_wr))
      else $error("sequence flag dropped without a control write");
   AST_FLAG_SOURCE: assert property (@(posedge pclk) disable iff (!presetn) // R15
      (conversion_done_flags & ~$past(conversion_done_flags)) != 8'h00
         |-> $past(res_wr))
      else $error("slot done flag set without a result write");
endmodule

/* src/adcseq_pkg.sv */
// Purpose: shared constants and types of the conversion sequencer
// Assumes: 32-bit APB register window, byte addresses
// Notes:   every offset, field position and control field reset value lives here once
package adcseq_pkg;
   // register byte offsets
   localparam logic [7:0] ADCSEQ_CTRL_OFF  = 8'h00;
   localparam logic [7:0] ADCSEQ_STAT_OFF  = 8'h04;
   localparam logic [7:0] ADCSEQ_RES_BASE  = 8'h20;
   localparam logic [7:0] ADCSEQ_RES_END   = 8'h3C;
   // conversion_control_reg fields
   localparam int ADCSEQ_CHAN_LSB   = 0;
   localparam int ADCSEQ_EIGHT_BIT  = 4;
   localparam int ADCSEQ_MULTI_BIT  = 5;
   localparam int ADCSEQ_REPEAT_BIT = 6;
   localparam logic [3:0] ADCSEQ_CHAN_RST = 4'h0;
   localparam logic [2:0] ADCSEQ_MODE_RST = 3'h0;
   // converter_status_reg fields
   localparam int ADCSEQ_STAT_DONE_LSB = 0;
   localparam int ADCSEQ_STAT_SEQ_BIT  = 8;
   localparam int ADCSEQ_STAT_BUSY_BIT = 9;
   localparam int ADCSEQ_STAT_SLOT_LSB = 12;
   localparam int ADCSEQ_STAT_CHAN_LSB = 16;
   // mode word bit positions: {repeat, multi, eight}
   localparam int ADCSEQ_MODE_EIGHT  = 0;
   localparam int ADCSEQ_MODE_MULTI  = 1;
   localparam int ADCSEQ_MODE_REPEAT = 2;
   // sequence lengths
   localparam int ADCSEQ_LEN_SHORT = 4;
   localparam int ADCSEQ_LEN_LONG  = 8;
   typedef enum {ADCSEQ_IDLE, ADCSEQ_START, ADCSEQ_WAIT} adcseq_state_t;
endpackage

/* src/adcseq_chan_map.sv */
// Purpose: input channel for one conversion of a sequence
// Assumes: 4-bit channel code, slot index counts from zero
// Notes:   purely combinational
`timescale 1ns/100ps
module adcseq_chan_map (
   input  wire logic [3:0] base_chan,
   input  wire logic       multi,
   input  wire logic       eight,
   input  wire logic [2:0] slot,
   output logic      [3:0] chan
);
   always_comb
   begin
      if (!multi)
         chan = base_chan;
      else if (eight)
         chan = {base_chan[3], slot};                       // R19 R9 R13
      else
         chan = {base_chan[3:2], slot[1:0]};                // R19 R8 R12
   end
endmodule

/* src/adcseq_result_bank.sv */
// Purpose: result slot storage with one write and one read port
// Assumes: write index always below SLOTS
// Notes:   a new result simply overwrites the slot
`timescale 1ns/100ps
module adcseq_result_bank #(
   parameter int SLOTS = 8,
   parameter int WIDTH = 10
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(SLOTS)-1:0] wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(SLOTS)-1:0] rd_idx,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] slot_q [SLOTS];
   logic [WIDTH-1:0] slot_d [SLOTS];

   genvar i;
   generate
      for (i = 0; i < SLOTS; i++)
      begin : g_slot
         always_comb
         begin
            slot_d[i] = slot_q[i];
            if (wr_en && (int'(wr_idx) == i))
               slot_d[i] = wr_data;                         // R14
         end
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               slot_q[i] <= '0;
            else
               slot_q[i] <= slot_d[i];
         end
      end
   endgenerate

   assign rd_data = slot_q[rd_idx];
endmodule

/* test/adcseq_front_model.sv */
// Purpose: behavioural analog front end answering the sequencer
// Assumes: lat of zero means the converter never answers
// Notes:   a new start drops any conversion still in flight
`timescale 1ns/100ps
module adcseq_front_model #(
   parameter int RES_W = 10
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             conv_start,
   input  wire logic [3:0]       conv_channel,
   input  wire logic [3:0]       lat,
   output logic                  conv_done,
   output logic      [RES_W-1:0] conv_result
);
   int         cnt;
   logic [5:0] serial;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 0;
         serial <= 6'h00;
         conv_done <= 1'b0;
         conv_result <= '0;
      end
      else
      begin
         conv_done <= 1'b0;
         // toggling data, so a stale value never looks valid
         conv_result <= ~conv_result;
         if (conv_start)
            cnt <= (lat == 4'h0) ? -1 : int'(lat);
         else if (cnt > 1)
            cnt <= cnt - 1;
         else if (cnt == 1)
         begin
            cnt <= 0;
            serial <= serial + 6'h01;
            conv_done <= 1'b1;
            conv_result <= RES_W'({conv_channel, serial});
         end
      end
   end
endmodule

/* test/adc_conversion_sequencer_test.sv */
// Purpose: self-checking bench of the conversion sequencer
// Assumes: front end model answers after lat cycles, never for zero
// Notes:   expectations are tracked from the traffic at the ports
`timescale 1ns/100ps
module adc_conversion_sequencer_test;
   localparam int RES_W = 10;
   logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic             pwrite = 1'b0, armed = 1'b0, err, pready, pslverr;
   logic [7:0]       paddr = 8'h00, exp_flags = 8'h00, conversion_done_flags;
   logic [31:0]      pwdata = 32'h0, prdata, rd, ctrl;
   logic             conv_start, conv_done, sequence_done_flag;
   logic [3:0]       conv_channel, base = 4'h0, lat = 4'h1;
   logic [RES_W-1:0] conv_result;
   logic [RES_W-1:0] exp_res [8];
   logic [2:0]       mode = 3'h0;
   int               errors = 0, n_checks = 0, n_start = 0, n_done = 0, cur_slot = 0;
   int               m, ch;

   always #5 pclk = ~pclk;

   adcseq_top #(.NUM_SLOTS(8), .RES_W(RES_W)) u_adcseq_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_result(conv_result),
      .conversion_done_flags(conversion_done_flags),
      .sequence_done_flag(sequence_done_flag));

   adcseq_front_model #(.RES_W(RES_W)) u_adcseq_front_model (
      .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
      .conv_channel(conv_channel), .lat(lat), .conv_done(conv_done),
      .conv_result(conv_result));

   function automatic int seq_len();
      return mode[0] ? 8 : 4;
   endfunction

   // multi modes start on an aligned block of four or eight codes
   function automatic logic [3:0] exp_chan(input int slot);
      if (!mode[1])
         return base;
      return (mode[0] ? (base & 4'h8) : (base & 4'hC)) + 4'(slot);
   endfunction

   task automatic results;
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
      begin
         errors++;
         results();
      end
   endtask

   task automatic wait_for(input bit seq, input int n);
      int i;
      for (i = 0; i < 3000; i++)
      begin
         @(posedge pclk);
         #1;
         if (seq ? (sequence_done_flag === 1'b1) : (n_done >= n))
            break;
      end
      if (i == 3000)
      begin
         errors++;
         results();
      end
   endtask

   task automatic check_end(input int len);
      int s;
      chk("done flags", (32'h1 << len) - 32'h1, conversion_done_flags);
      chk("sequence flag", 1, sequence_done_flag);
      for (s = 0; s < len; s++)
      begin
         apb(1'b0, paddr_res(s), 32'h0);
         chk("result slot", exp_res[s], rd[RES_W-1:0]);
         chk("result read error", 0, err);
      end
      apb(1'b0, adcseq_pkg::ADCSEQ_STAT_OFF, 32'h0);
      chk("status flags", {1'b1, exp_flags}, rd[8:0]);
   endtask

   function automatic logic [7:0] paddr_res(input int s);
      return adcseq_pkg::ADCSEQ_RES_BASE + 8'(4 * s);
   endfunction

   // conv_done is handled before a control write, as the write wins
   always @(posedge pclk)
   begin
      if (conv_done && armed)
      begin
         exp_res[cur_slot] = conv_result;
         exp_flags[cur_slot] = 1'b1;
         n_done++;
         armed = 1'b0;
      end
      if (psel && penable && pready && pwrite && paddr == adcseq_pkg::ADCSEQ_CTRL_OFF)
      begin
         {mode, base} = pwdata[6:0];
         {n_start, n_done, exp_flags, armed} = '0;
      end
      if (conv_start)
      begin
         cur_slot = n_start % seq_len();
         chk("channel", exp_chan(cur_slot), conv_channel);
         n_start++;
         armed = 1'b1;
      end
   end

   initial
   begin
      void'($urandom(32'h26F5));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      #1;
      chk("starts after reset", 0, n_start);
      chk("flags after reset", 0, {sequence_done_flag, conversion_done_flags});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped read error", 1, err);
      apb(1'b1, adcseq_pkg::ADCSEQ_STAT_OFF, 32'hFF);
      chk("status write error", 1, err);
      apb(1'b1, adcseq_pkg::ADCSEQ_RES_BASE, 32'h3FF);
      chk("result write error", 1, err);
      for (m = 0; m < 8; m++)
      begin
         ch = $urandom % 16;
         lat <= 4'h1 + 4'($urandom % 4);
         ctrl = 32'(m * 16 + ch);
         apb(1'b1, adcseq_pkg::ADCSEQ_CTRL_OFF, ctrl);
         chk("control write error", 0, err);
         apb(1'b0, adcseq_pkg::ADCSEQ_CTRL_OFF, 32'h0);
         chk("control readback", ctrl, rd & 32'h7F);
         chk("control read error", 0, err);
         wait_for(1'b1, 0);
         chk("done count at sequence flag", seq_len(), n_done);
         // stall the front end so results hold still while read
         if (m > 3)
            wait_for(1'b0, seq_len() + 2);
         lat <= 4'h0;
         repeat (40) @(posedge pclk);
         #1;
         if (m > 3)
            chk("repeat continues", 1, n_start > seq_len() + 2);
         else
            chk("single pass stops", seq_len(), n_start);
         check_end(seq_len());
      end
      lat <= 4'h5;
      apb(1'b1, adcseq_pkg::ADCSEQ_CTRL_OFF, 32'h39);
      wait_for(1'b0, 2);
      apb(1'b1, adcseq_pkg::ADCSEQ_CTRL_OFF, 32'h05);
      @(posedge pclk);
      #1;
      chk("flags after abort", 0, {sequence_done_flag, conversion_done_flags});
      wait_for(1'b1, 0);
      repeat (40) @(posedge pclk);
      #1;
      chk("restarted sequence", 4, n_start);
      check_end(4);
      results();
   end
endmodule
